//--- rtl/lpc_frontend.v
`timescale 1ns/1ps
`include "lpc_map.vh"
module lpc_frontend (
    input wire clk_sys,
    input wire arst_n,
    input wire [12:0] in_sample,
    input wire in_valid,
    output wire in_ready,
    input wire out_ready,
    output wire out_valid,
    output wire [15:0] out_sample,
    output wire [1:0] out_set,
    output wire [127:0] out_coef,
    output wire [35:0] code_index,
    output wire frame_done
);
    localparam ST_IN = 3'b000;
    localparam ST_ACF = 3'b001;
    localparam ST_NORM = 3'b010;
    localparam ST_SINIT = 3'b011;
    localparam ST_SDIV = 3'b100;
    localparam ST_SUPD = 3'b101;
    localparam ST_LAR = 3'b110;
    localparam ST_OUT = 3'b111;

    wire [127:0] tab_a = `LPC_A_TAB;
    wire [127:0] tab_b = `LPC_B_TAB;
    wire [127:0] tab_i = `LPC_I_TAB;
    wire [31:0] tab_w = `LPC_W_TAB;
    wire [47:0] tab_o = `LPC_O_TAB;
    reg [2:0] state_r;
    reg [7:0] ptr_r;
    reg [3:0] k_r, dcnt_r;
    reg [15:0] rem_r, quo_r;
    reg signed [47:0] acc_r;
    reg signed [15:0] frame_r [0:159];
    reg signed [47:0] acf_r [0:8];
    reg signed [15:0] p_r [0:8], kk_r [0:8], rc_r [0:8];
    reg signed [15:0] cur_r [0:7], prev_r [0:7];
    reg signed [15:0] s0prev_r, sofprev_r;
    reg signed [31:0] sofacc_r;
    reg in_ready_r, out_valid_r, frame_done_r;
    reg [15:0] out_sample_r;
    reg [1:0] out_set_r;
    reg [127:0] out_coef_r;
    reg [35:0] code_r;
    assign in_ready = in_ready_r;
    assign out_valid = out_valid_r;
    assign out_sample = out_sample_r;
    assign out_set = out_set_r;
    assign out_coef = out_coef_r;
    assign code_index = code_r;
    assign frame_done = frame_done_r;
    function signed [15:0] mr;
        input signed [15:0] a;
        input signed [15:0] b;
        reg signed [31:0] t;
        begin
            t = a * b + `LPC_RND;
            mr = t[30:15];
        end
    endfunction
    function signed [15:0] r2lar;
        input signed [15:0] r;
        reg [15:0] a;
        reg [15:0] h;
        begin
            a = r[15] ? -r : r;
            if (a < `LPC_T1) begin
                h = a >> 1;
            end else if (a < `LPC_T2) begin
                h = a - `LPC_OFS1;
            end else begin
                h = (a - `LPC_OFS2) << 2;
            end
            r2lar = r[15] ? -h : h;
        end
    endfunction
    function signed [7:0] quant;
        input signed [15:0] h;
        input [15:0] av;
        input signed [15:0] bv;
        input [3:0] w;
        reg signed [32:0] m;
        reg signed [31:0] z;
        reg signed [31:0] zr;
        reg signed [31:0] qq;
        reg signed [31:0] lim;
        begin
            m = h * $signed({1'b0, av});
            z = $signed(m[32:`LPC_QF]) + bv;
            zr = z[31] ? z - `LPC_RNDQ : z + `LPC_RNDQ;
            qq = zr[31] ? -((-zr) >>> `LPC_QSH) : zr >>> `LPC_QSH;
            lim = 32'sh1 <<< (w - 4'h1);
            if (qq >= lim) begin
                quant = lim[7:0] - 8'h01;
            end else if (qq < -lim) begin
                quant = 8'h00 - lim[7:0];
            end else begin
                quant = qq[7:0];
            end
        end
    endfunction
    function signed [15:0] lar2rc;
        input signed [15:0] x;
        reg [15:0] a;
        reg [15:0] t;
        begin
            a = x[15] ? -x : x;
            if (a < `LPC_U1) begin
                t = a << 1;
            end else if (a < `LPC_U2) begin
                t = a + `LPC_U1;
            end else begin
                t = (a >> 2) + `LPC_OFS2;
            end
            lar2rc = x[15] ? -t : t;
        end
    endfunction
    function signed [15:0] interp;
        input signed [15:0] p;
        input signed [15:0] c;
        input [1:0] s;
        begin
            case (s)
                2'h0: interp = (p >>> 2) + (c >>> 2) + (p >>> 1);
                2'h1: interp = (p >>> 1) + (c >>> 1);
                2'h2: interp = (p >>> 2) + (c >>> 2) + (c >>> 1);
                default: interp = c;
            endcase
        end
    endfunction

    // Input filters are stepped only on an accepted sample.
    wire signed [15:0] s0 = {in_sample, 3'b000};
    wire signed [16:0] dif = s0 - s0prev_r;
    wire signed [48:0] fb = sofacc_r * $signed({1'b0, `LPC_ALPHA});
    wire signed [31:0] sofacc_nxt = {dif, 15'h0000} + fb[46:15];
    wire signed [31:0] sofr = sofacc_nxt + `LPC_RND;
    wire signed [15:0] sof = sofr[30:15];
    wire signed [32:0] pe = sofprev_r * $signed({1'b0, `LPC_BETA});
    wire signed [15:0] s_new = sof - pe[30:15];
    wire accept = in_valid & in_ready_r;

    wire signed [31:0] prod = frame_r[ptr_r] * frame_r[ptr_r - {4'h0, k_r}];
    wire signed [15:0] p1 = p_r[1];
    wire [15:0] absp1 = p1[15] ? -p1 : p1;
    wire [16:0] remsh = {rem_r, 1'b0};
    wire [16:0] remdf = remsh - {1'b0, p_r[0]};
    wire signed [15:0] rv = p1[15] ? quo_r : -quo_r;
    wire [1:0] set_w = (ptr_r < `LPC_SEG1) ? 2'h0 : (ptr_r < `LPC_SEG2) ? 2'h1 :
                       (ptr_r < `LPC_SEG3) ? 2'h2 : 2'h3;

    reg signed [15:0] cur_nxt [0:7];
    reg [35:0] code_nxt;
    reg [127:0] coef_nxt;
    reg signed [7:0] q_t;
    reg [5:0] fld_t;
    reg [3:0] w_t;
    integer c, j;
    always @* begin
        code_nxt = 36'h0;
        coef_nxt = 128'h0;
        q_t = 8'h00;
        fld_t = 6'h00;
        w_t = 4'h0;
        for (c = 0; c < 8; c = c + 1) begin
            w_t = tab_w[c*4 +: 4];
            q_t = quant(r2lar(rc_r[c+1]), tab_a[c*16 +: 16], tab_b[c*16 +: 16], w_t);
            cur_nxt[c] = mr($signed(tab_i[c*16 +: 16]),
                (q_t <<< `LPC_DSH) - ($signed(tab_b[c*16 +: 16]) <<< 1)) <<< 1;
            fld_t = (q_t[5:0] ^ (6'h01 << (w_t - 4'h1))) & ((6'h01 << w_t) - 6'h01);
            code_nxt = code_nxt | ({30'h0, fld_t} << tab_o[c*6 +: 6]);
            coef_nxt[c*16 +: 16] = lar2rc(interp(prev_r[c], cur_r[c], set_w));
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IN;
            ptr_r <= 8'h00;
            k_r <= 4'h0;
            dcnt_r <= 4'h0;
            rem_r <= 16'h0000;
            quo_r <= 16'h0000;
            acc_r <= 48'h0;
            s0prev_r <= 16'h0000;
            sofprev_r <= 16'h0000;
            sofacc_r <= 32'h0;
            in_ready_r <= 1'b1;
            out_valid_r <= 1'b0;
            out_sample_r <= 16'h0000;
            out_set_r <= 2'h0;
            out_coef_r <= 128'h0;
            code_r <= 36'h0;
            frame_done_r <= 1'b0;
            for (j = 0; j < 160; j = j + 1) begin
                frame_r[j] <= 16'h0000;
            end
            for (j = 0; j < 9; j = j + 1) begin
                acf_r[j] <= 48'h0;
                p_r[j] <= 16'h0000;
                kk_r[j] <= 16'h0000;
                rc_r[j] <= 16'h0000;
            end
            for (j = 0; j < 8; j = j + 1) begin
                cur_r[j] <= 16'h0000;
                prev_r[j] <= 16'h0000;
            end
        end else begin
            frame_done_r <= 1'b0;
            case (state_r)
                ST_IN: begin
                    if (accept) begin
                        s0prev_r <= s0;
                        sofacc_r <= sofacc_nxt;
                        sofprev_r <= sof;
                        frame_r[ptr_r] <= s_new;
                        if (ptr_r == `LPC_LAST) begin
                            in_ready_r <= 1'b0;
                            ptr_r <= 8'h00;
                            k_r <= 4'h0;
                            acc_r <= 48'h0;
                            state_r <= ST_ACF;
                        end else begin
                            ptr_r <= ptr_r + 8'h01;
                        end
                    end
                end
                ST_ACF: begin
                    if (ptr_r == `LPC_LAST) begin
                        acf_r[k_r] <= acc_r + prod;
                        acc_r <= 48'h0;
                        if (k_r == `LPC_ORD) begin
                            state_r <= ST_NORM;
                        end else begin
                            k_r <= k_r + 4'h1;
                            ptr_r <= {4'h0, k_r} + 8'h01;
                        end
                    end else begin
                        acc_r <= acc_r + prod;
                        ptr_r <= ptr_r + 8'h01;
                    end
                end
                ST_NORM: begin
                    if (acf_r[0] == 48'h0 || acf_r[0][`LPC_TOPBIT]) begin
                        for (j = 0; j < 9; j = j + 1) begin
                            p_r[j] <= acf_r[j][47:32];
                            kk_r[j] <= acf_r[j][47:32];
                        end
                        k_r <= 4'h1;
                        state_r <= ST_SINIT;
                    end else begin
                        for (j = 0; j < 9; j = j + 1) begin
                            acf_r[j] <= acf_r[j] <<< 1;
                        end
                    end
                end
                ST_SINIT: begin
                    if (p_r[0] == 16'h0000 || $unsigned(p_r[0]) < absp1) begin
                        for (j = 1; j < 9; j = j + 1) begin
                            if (j >= k_r) begin
                                rc_r[j] <= 16'h0000;
                            end
                        end
                        state_r <= ST_LAR;
                    end else begin
                        rem_r <= absp1;
                        quo_r <= 16'h0000;
                        dcnt_r <= 4'h0;
                        state_r <= ST_SDIV;
                    end
                end
                ST_SDIV: begin
                    if (!remdf[16]) begin
                        rem_r <= remdf[15:0];
                        quo_r <= {quo_r[14:0], 1'b1};
                    end else begin
                        rem_r <= remsh[15:0];
                        quo_r <= {quo_r[14:0], 1'b0};
                    end
                    dcnt_r <= dcnt_r + 4'h1;
                    if (dcnt_r == `LPC_DIVLAST) begin
                        state_r <= ST_SUPD;
                    end
                end
                ST_SUPD: begin
                    rc_r[k_r] <= rv;
                    if (k_r == `LPC_ORD) begin
                        state_r <= ST_LAR;
                    end else begin
                        p_r[0] <= p_r[0] + mr(p1, rv);
                        for (j = 1; j < 8; j = j + 1) begin
                            if (j <= 8 - k_r) begin
                                p_r[j] <= p_r[j+1] + mr(kk_r[j], rv);
                                kk_r[j] <= kk_r[j] + mr(p_r[j+1], rv);
                            end
                        end
                        k_r <= k_r + 4'h1;
                        state_r <= ST_SINIT;
                    end
                end
                ST_LAR: begin
                    for (j = 0; j < 8; j = j + 1) begin
                        cur_r[j] <= cur_nxt[j];
                    end
                    code_r <= code_nxt;
                    frame_done_r <= 1'b1;
                    ptr_r <= 8'h00;
                    state_r <= ST_OUT;
                end
                ST_OUT: begin
                    // Readout starts microseconds after the last sample, far inside the budget.
                    if (!out_valid_r || out_ready) begin
                        if (ptr_r <= `LPC_LAST) begin
                            out_valid_r <= 1'b1;
                            out_sample_r <= frame_r[ptr_r];
                            out_set_r <= set_w;
                            out_coef_r <= coef_nxt;
                            ptr_r <= ptr_r + 8'h01;
                        end else begin
                            out_valid_r <= 1'b0;
                            for (j = 0; j < 8; j = j + 1) begin
                                prev_r[j] <= cur_r[j];
                            end
                            ptr_r <= 8'h00;
                            in_ready_r <= 1'b1;
                            state_r <= ST_IN;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IN;
                end
            endcase
        end
    end
endmodule

//--- rtl/lpc_map.vh
`ifndef LPC_MAP_VH
`define LPC_MAP_VH
// Contract
// - Accept 13-bit linear samples at 8 kHz.
// - Notch out DC, alpha 32735/2^15.
// - Pre-emphasis FIR, beta 28180/2^15.
// - 160-sample frames, one order-8 analysis each.
// - Nine autocorrelation lags 0..8 per frame.
// - Eight reflection coefficients by Schur recursion.
// - Piecewise reflection to log-area mapping.
// - Piecewise log-area back to reflection mapping.
// - Index is scaled ratio plus bias, rounded.
// - Coefficients 1-2: scale 20, limits -32..31.
// - Coefficients 3-4: biases 4/-5, limits -16..15.
// - Coefficients 5-6 scale/bias, limits -8..7.
// - Coefficients 7-8 scale/bias, limits -4..3.
// - Decode index: subtract bias, divide by scale.
// - Blend previous/current ratios over four ranges.
// - Four coefficient sets per frame.
// - Hold frame until parameters done, then read.
// - Filter coefficients via inverse mapping.
// - Encode plus decode delay below 30 ms.
// - Indices packed 6,6,5,5,4,4,3,3 bits, LSB first.
`define LPC_LAST 8'h9f
`define LPC_ORD 4'h8
`define LPC_SEG1 8'h0d
`define LPC_SEG2 8'h1b
`define LPC_SEG3 8'h28
`define LPC_ALPHA 16'h7fdf
`define LPC_BETA 16'h6e14
`define LPC_QF 15
`define LPC_RND 32'sh00004000
`define LPC_TOPBIT 46
`define LPC_DIVLAST 4'he
`define LPC_T1 16'h5666
`define LPC_T2 16'h799a
`define LPC_OFS1 16'h2b33
`define LPC_OFS2 16'h6600
`define LPC_U1 16'h2b33
`define LPC_U2 16'h4e66
`define LPC_RNDQ 32'sh00000100
`define LPC_QSH 9
`define LPC_DSH 10
// Scale times 1024, bias times 512, 2^18 over scale; coefficient 1 in the low lane.
`define LPC_A_TAB {16'h234c,16'h2156,16'h3c00,16'h368c,16'h5000,16'h5000,16'h5000,16'h5000}
`define LPC_B_TAB {16'hfb88,16'hfeab,16'hf900,16'h005e,16'hf600,16'h0800,16'h0000,16'h0000}
`define LPC_I_TAB {16'h740c,16'h7ade,16'h4444,16'h4b17,16'h3333,16'h3333,16'h3333,16'h3333}
`define LPC_W_TAB {4'h3,4'h3,4'h4,4'h4,4'h5,4'h5,4'h6,4'h6}
`define LPC_O_TAB {6'h21,6'h1e,6'h1a,6'h16,6'h11,6'h0c,6'h06,6'h00}
`endif

//--- dv/lpc_fe_asserts.sv
`timescale 1ns/1ps
module lpc_fe_asserts (
    input wire clk_sys,
    input wire arst_n,
    input wire [12:0] in_sample,
    input wire in_valid,
    input wire in_ready,
    input wire out_ready,
    input wire out_valid,
    input wire [15:0] out_sample,
    input wire [1:0] out_set,
    input wire [127:0] out_coef,
    input wire [35:0] code_index,
    input wire frame_done
);
    reg [7:0] in_cnt_r;
    reg [7:0] out_cnt_r;
    wire take_in = in_valid && in_ready;
    wire take_out = out_valid && out_ready;
    wire last_out = take_out && out_cnt_r == 8'h9f;
    wire [1:0] set_exp = out_cnt_r < 8'h0d ? 2'h0 : out_cnt_r < 8'h1b ? 2'h1 :
        out_cnt_r < 8'h28 ? 2'h2 : 2'h3;
    // Counts samples taken since the last readout ended, and samples read out of this frame.
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            in_cnt_r <= 8'h00;
            out_cnt_r <= 8'h00;
        end else begin
            in_cnt_r <= last_out ? 8'h00 : in_cnt_r + {7'h00, take_in};
            out_cnt_r <= frame_done ? 8'h00 : out_cnt_r + {7'h00, take_out};
        end
    end
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    a_ready_drops_full: assert property (take_in && in_cnt_r == 8'h9f |=> !in_ready)
        else $error("input still ready after the last frame sample");
    a_done_one_pulse: assert property (frame_done |=> !frame_done)
        else $error("frame done longer than one cycle");
    a_done_after_frame: assert property (frame_done |-> in_cnt_r == 8'ha0 && !in_ready)
        else $error("frame done without a full frame held");
    a_read_follows_done: assert property (frame_done |=> out_valid && out_cnt_r == 8'h00)
        else $error("readout did not start after frame done");
    a_out_holds_stall: assert property (out_valid && !out_ready |=> out_valid &&
        $stable(out_sample) && $stable(out_set) && $stable(out_coef))
        else $error("readout changed while stalled");
    a_index_held_between: assert property (!frame_done |-> $stable(code_index))
        else $error("coded indices changed outside frame done");
    a_set_by_position: assert property (out_valid |-> out_set == set_exp)
        else $error("coefficient set does not match sample position");
    a_coef_within_set: assert property (out_valid && $past(out_valid) &&
        out_set == $past(out_set) |-> $stable(out_coef))
        else $error("coefficients changed inside one set");
    a_ready_back_last: assert property (last_out |=> in_ready && !out_valid)
        else $error("input not reopened after the last readout sample");
    a_busy_no_input: assert property (out_valid |-> !in_ready)
        else $error("input ready during readout");
endmodule
bind lpc_frontend lpc_fe_asserts i_chk (.clk_sys(clk_sys), .arst_n(arst_n),
    .in_sample(in_sample), .in_valid(in_valid), .in_ready(in_ready), .out_ready(out_ready),
    .out_valid(out_valid), .out_sample(out_sample), .out_set(out_set), .out_coef(out_coef),
    .code_index(code_index), .frame_done(frame_done));

//--- dv/lpc_fe_partner.sv
`timescale 1ns/1ps
module lpc_fe_partner (
    input wire clk_sys,
    input wire in_ready,
    output reg in_valid,
    output reg [12:0] in_sample,
    input wire out_valid,
    output reg out_ready,
    input wire stall_en
);
    logic [12:0] src_q[$];
    reg took_r;
    reg [1:0] ph_r;
    task push(input logic [12:0] v);
        src_q.push_back(v);
    endtask
    initial begin
        in_valid = 1'b0;
        in_sample = 13'h0000;
        out_ready = 1'b1;
        took_r = 1'b0;
        ph_r = 2'h0;
    end
    always @(posedge clk_sys) begin
        took_r <= in_valid && in_ready;
    end
    // A sample is held until taken; an idle bus is scrambled so no stale value looks valid.
    always @(negedge clk_sys) begin
        if (took_r) begin
            void'(src_q.pop_front());
        end
        if (src_q.size() > 0) begin
            in_valid <= 1'b1;
            in_sample <= src_q[0];
        end else begin
            in_valid <= 1'b0;
            in_sample <= ~in_sample;
        end
        ph_r <= ph_r + 2'h1;
        out_ready <= !stall_en || ph_r != 2'h0;
    end
endmodule

//--- dv/lpc_frontend_tb.sv
`timescale 1ns/1ps
module lpc_frontend_tb;
    reg clk_sys, arst_n, stall_en;
    wire [12:0] in_sample;
    wire in_valid, in_ready, out_ready, out_valid, frame_done;
    wire [15:0] out_sample;
    wire [1:0] out_set;
    wire [127:0] out_coef;
    wire [35:0] code_index;
    integer n_fail, checks_done, n_in, n_out, i, f, t, k, m, sx, pos;
    reg [15:0] lfsr_r;
    real xp, ofp, of, s;
    int exp_q[$];
    real ca[8] = '{20.0, 20.0, 20.0, 20.0, 13.637, 15.0, 8.334, 8.824};
    real cb[8] = '{0.0, 0.0, 4.0, -5.0, 0.184, -3.5, -0.666, -2.235};
    int wd[8] = '{6, 6, 5, 5, 4, 4, 3, 3};
    int cf[8];
    real dec[8];
    real pdec[8], pp[9], kk[9], rr[9], fr[160];
    real z, frac;
    int loose[8], ploose[8];
    integer ka, ia, qi, dead;

    lpc_frontend i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .in_sample(in_sample),
        .in_valid(in_valid), .in_ready(in_ready), .out_ready(out_ready), .out_valid(out_valid),
        .out_sample(out_sample), .out_set(out_set), .out_coef(out_coef),
        .code_index(code_index), .frame_done(frame_done));
    lpc_fe_partner i_part (.clk_sys(clk_sys), .in_ready(in_ready), .in_valid(in_valid),
        .in_sample(in_sample), .out_valid(out_valid), .out_ready(out_ready), .stall_en(stall_en));

    always #4 clk_sys = ~clk_sys;

    function [15:0] lfsr_next(input [15:0] v);
        lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function integer nint(input real z);
        nint = $rtoi(z + (z < 0.0 ? -0.5 : 0.5));
    endfunction
    function real inv_map(input real x);
        real a;
        a = x < 0.0 ? -x : x;
        if (a >= 0.675) a = a < 1.225 ? 0.5 * a + 0.3375 : 0.125 * a + 0.796875;
        inv_map = x < 0.0 ? -a : a;
    endfunction
    // Reference analysis in reals; an index within 0.2 of a rounding step may land either
    // way in fixed point, so it is marked loose and earns one step of tolerance.
    task analyse;
        dead = 0;
        for (ka = 0; ka < 9; ka++) begin
            pp[ka] = 0.0;
            for (ia = ka; ia < 160; ia++) pp[ka] += fr[ia] * fr[ia - ka];
            kk[ka] = pp[ka];
            rr[ka] = 0.0;
        end
        for (ka = 1; ka < 9; ka++) begin
            if (pp[0] <= 0.0 || pp[0] < (pp[1] < 0.0 ? -pp[1] : pp[1])) dead = 1;
            if (!dead) begin
                rr[ka] = -pp[1] / pp[0];
                pp[0] += pp[1] * rr[ka];
                for (ia = 1; ia <= 8 - ka; ia++) begin
                    pp[ia] = pp[ia + 1] + kk[ia] * rr[ka];
                    kk[ia] += pp[ia + 1] * rr[ka];
                end
            end
        end
        for (ka = 0; ka < 8; ka++) begin
            pdec[ka] = dec[ka];
            ploose[ka] = loose[ka];
            z = rr[ka + 1] < 0.0 ? -rr[ka + 1] : rr[ka + 1];
            z = z < 0.675 ? z : z < 0.95 ? 2.0 * z - 0.675 : 8.0 * z - 6.375;
            z = ca[ka] * (rr[ka + 1] < 0.0 ? -z : z) + cb[ka];
            frac = (z < 0.0 ? -z : z) - $rtoi(z < 0.0 ? -z : z);
            loose[ka] = rr[ka + 1] != 0.0 && frac > 0.3 && frac < 0.7;
            qi = nint(z);
            qi = qi < -(1 << (wd[ka] - 1)) ? -(1 << (wd[ka] - 1)) : qi;
            qi = qi > (1 << (wd[ka] - 1)) - 1 ? (1 << (wd[ka] - 1)) - 1 : qi;
            cf[ka] = qi + (1 << (wd[ka] - 1));
            dec[ka] = (qi - cb[ka]) / ca[ka];
        end
    endtask
    task check(input string nm, input logic signed [31:0] seen, input integer ex,
        input integer tol);
        checks_done++;
        if ((^seen) === 1'bx || seen - ex > tol || ex - seen > tol) begin
            n_fail++;
            $display("unexpected %s expected %0d seen %0d", nm, ex, seen);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        if (arst_n && in_valid && in_ready) begin
            of = $signed(in_sample) - xp + 32735.0 / 32768.0 * ofp;
            s = of - 28180.0 / 32768.0 * ofp;
            xp = $signed(in_sample);
            ofp = of;
            fr[n_in % 160] = s * 8.0;
            exp_q.push_back(nint(s * 8.0));
            n_in++;
        end
        if (arst_n && frame_done) begin
            analyse;
            check("frame_size", n_in - n_out, 160, 0);
            pos = 0;
            for (k = 0; k < 8; k++) begin
                check("code_field", (code_index >> pos) & ((36'h1 << wd[k]) - 1), cf[k],
                    loose[k]);
                pos = pos + wd[k];
            end
        end
        if (arst_n && out_valid && out_ready) begin
            check("out_sample", $signed(out_sample), exp_q.pop_front(), 4);
            t = n_out % 160;
            sx = t < 13 ? 0 : t < 27 ? 1 : t < 40 ? 2 : 3;
            check("out_set", out_set, sx, 0);
            for (k = 0; k < 8; k++) begin
                check("out_coef", $signed(out_coef[16 * k +: 16]), nint(32768.0 *
                    inv_map(pdec[k] + (dec[k] - pdec[k]) * (sx + 1) / 4.0)),
                    16 + 4100 * (loose[k] | ploose[k]));
            end
            n_out++;
        end
    end

    initial begin
        #(8 * 20000);
        n_fail++;
        report_and_stop;
    end

    initial begin
        clk_sys = 1'b0;
        arst_n = 1'b0;
        stall_en = 1'b0;
        {n_fail, checks_done, n_in, n_out} = 0;
        xp = 0.0;
        ofp = 0.0;
        lfsr_r = 16'h0045;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        check("ready_in_reset", in_ready, 1, 0);
        check("busy_in_reset", {out_valid, frame_done}, 0, 0);
        check("index_in_reset", |code_index, 0, 0);
        arst_n = 1'b1;
        for (f = 0; f < 3; f++) begin
            stall_en = f > 0;
            for (i = 0; i < 160; i++) begin
                lfsr_r = lfsr_next(lfsr_r);
                i_part.push(f < 2 ? 13'h0000 : {{3{lfsr_r[9]}}, lfsr_r[9:0]});
            end
            for (m = 0; m < 4000 && n_out < 160 * (f + 1); m++) @(posedge clk_sys);
            @(negedge clk_sys);
        end
        check("frames_out", n_out, 480, 0);
        report_and_stop;
    end
endmodule
